/* File: core/pg_params.svh */
`ifndef PG_PARAMS_SVH
`define PG_PARAMS_SVH
// Register byte addresses (lower 16 bits decoded)
`define PG_ADDR_DIR 16'hfebf
`define PG_ADDR_DATA 16'hff6f
`define PG_ADDR_PIN 16'hff5f
`define PG_ADDR_FC1 16'hff45
`define PG_ADDR_FC2 16'hffac
`define PG_ADDR_CFG 16'hff00
// Reset values
`define PG_DIR_RST_M45 5'h10
`define PG_DIR_RST_M67 5'h00
`define PG_DATA_RST 5'h00
`define PG_FC1_RST 8'h0f
`define PG_FC2_RST 8'h30
`define PG_CFG_RST 8'h00
// Field positions
`define PG_FC1_CS5S 5
`define PG_FC1_CS4S 4
`define PG_FC2_SELECT_GROUP_TWO_TO_FIVE_ENABLE 4
`define PG_FC2_CS167E 5
`define PG_FC1_CSS17 7
`define PG_FC1_CSS36 6
`define PG_CFG_BUS_RELEASE_ENABLE 0
`define PG_CFG_KEEP 1
`define PG_CFG_F1DIR 2
`define PG_CFG_F0DIR 3
`define PG_CFG_F1DAT 4
`define PG_CFG_F0DAT 5
`define PG_PORT_W 5
`endif

/* File: core/pg_pkg.sv */
package pg_pkg;
  typedef enum logic [1:0] {
    PG_FN_IN,
    PG_FN_PORT_OUT,
    PG_FN_SELECT_OUT,
    PG_FN_BUS_REL
  } pg_fn_t;
  typedef struct packed {
    logic [4:0] dir;
    logic [4:0] data;
    logic [7:0] fc1;
    logic [7:0] fc2;
    logic [7:0] cfg;
  } pg_regs_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
  } pg_acc_t;
endpackage

/* File: core/pg_port.sv */
// Implementation choice: register access over AXI4-Lite.
`include "pg_params.svh"
// Functional notes
// - Modes 4-6, no release: F1 input if dir 0; CS5 if enable and select; else port.
// - F1 is bus acknowledge when release enabled in modes 4-6; mode 7 port only.
// - F0 likewise with CS4 select; bus request when release enabled; mode 7 port.
// - Interrupt 0 and 1 always follow F0 and F1 pins; use as port input.
// - Modes 6 and 7 unavailable on ROM-less variant.
// - Port G has five bidirectional pins sharing selects, trigger and interrupts.
// - Chip selects 0-3, 6, 7 route onto port G pins.
// - Direction register is write-only; reads undefined (zero); bits 7-5 reserved.
// - Reset loads direction 10 in modes 4/5, 00 in 6/7; standby retains.
// - Standby output-keep bit selects hold or float of bus control pins.
// - Data register read/write, reset to 00, kept in software standby.
// - Reserved bits 7-5 of data and pin registers read zero, writes ignored.
// - Pin-state register is read-only; writes do nothing.
// - Pin-state read gives data bit when output, pin level when input.
// - Pin-state follows pins after reset; held in software standby.
// - Decode lower 16 address bits at FEBF, FF6F, FF5F, FF45, FFAC.
// - With release disabled, request and acknowledge pins are port pins or CS4/CS5 selects.
module pg_port (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Mode and standby
  input wire logic [2:0] mode_in,
  input wire logic rom_less_in,
  input wire logic sw_standby_in,
  // AXI4-Lite write
  input wire logic [31:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read
  input wire logic [31:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Port G pins
  input wire logic [4:0] pg_pin_in,
  output logic [4:0] pg_pin_out,
  output logic [4:0] pg_pin_oe_out,
  // Chip-select sources for port G and port F bits 1 and 0
  input wire logic [7:0] chip_select_n_in,
  // Port F bits 1 and 0
  input wire logic [1:0] pf_pin_in,
  output logic [1:0] pf_pin_out,
  output logic [1:0] pf_pin_oe_out,
  input wire logic bus_ack_n_in,
  // Decoded inputs
  output logic ext_interrupt_zero_out,
  output logic ext_interrupt_one_out,
  output logic ext_interrupt_six_out,
  output logic ext_interrupt_seven_out,
  output logic converter_trigger_input_out,
  output logic bus_request_input_out,
  // Status
  output logic mode_error_out
);
  // Register state
  pg_pkg::pg_regs_t regs_q;
  pg_pkg::pg_regs_t regs_d;
  logic [4:0] dir_rst;
  logic [4:0] pin_view_q;
  logic [4:0] pin_view_d;

  // Write channel state
  logic aw_full_q;
  logic aw_full_d;
  logic w_full_q;
  logic w_full_d;
  logic [15:0] awaddr_q;
  logic [15:0] awaddr_d;
  logic [7:0] wdata_q;
  logic [7:0] wdata_d;
  logic wstrb_q;
  logic wstrb_d;
  logic bvalid_q;
  logic bvalid_d;
  logic [1:0] bresp_q;
  logic [1:0] bresp_d;

  // Read channel state
  logic rvalid_q;
  logic rvalid_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0] rresp_q;
  logic [1:0] rresp_d;

  // Decode and pin selection
  logic [4:0] pg_view;
  logic bus_mode;
  logic bus_release_enable;
  logic keep_out;
  logic select_group_two_to_five_enable;
  logic cs167e;
  logic do_write;
  logic hit_w;
  logic [7:0] rd_byte;
  logic rd_hit;
  pg_pkg::pg_fn_t f1_fn;
  pg_pkg::pg_fn_t f0_fn;
  logic [4:0] pg_sel_en;
  logic [4:0] pg_sel_val;

  assign bus_mode = (mode_in == 3'h4) || (mode_in == 3'h5) || (mode_in == 3'h6);
  assign dir_rst = ((mode_in == 3'h4) || (mode_in == 3'h5)) ? `PG_DIR_RST_M45 : `PG_DIR_RST_M67;
  assign mode_error_out = rom_less_in && ((mode_in == 3'h6) || (mode_in == 3'h7));
  assign bus_release_enable = regs_q.cfg[`PG_CFG_BUS_RELEASE_ENABLE];
  assign keep_out = regs_q.cfg[`PG_CFG_KEEP];
  assign select_group_two_to_five_enable = regs_q.fc2[`PG_FC2_SELECT_GROUP_TWO_TO_FIVE_ENABLE];
  assign cs167e = regs_q.fc2[`PG_FC2_CS167E];

  // Port F bit 1 and bit 0 function selection
  always_comb begin
    if (bus_mode && bus_release_enable) begin
      f1_fn = pg_pkg::PG_FN_BUS_REL;
      f0_fn = pg_pkg::PG_FN_BUS_REL;
    end else if (bus_mode) begin
      if (!regs_q.cfg[`PG_CFG_F1DIR]) begin
        f1_fn = pg_pkg::PG_FN_IN;
      end else if (select_group_two_to_five_enable && regs_q.fc1[`PG_FC1_CS5S]) begin
        f1_fn = pg_pkg::PG_FN_SELECT_OUT;
      end else begin
        f1_fn = pg_pkg::PG_FN_PORT_OUT;
      end
      if (!regs_q.cfg[`PG_CFG_F0DIR]) begin
        f0_fn = pg_pkg::PG_FN_IN;
      end else if (select_group_two_to_five_enable && regs_q.fc1[`PG_FC1_CS4S]) begin
        f0_fn = pg_pkg::PG_FN_SELECT_OUT;
      end else begin
        f0_fn = pg_pkg::PG_FN_PORT_OUT;
      end
    end else begin
      f1_fn = regs_q.cfg[`PG_CFG_F1DIR] ? pg_pkg::PG_FN_PORT_OUT : pg_pkg::PG_FN_IN;
      f0_fn = regs_q.cfg[`PG_CFG_F0DIR] ? pg_pkg::PG_FN_PORT_OUT : pg_pkg::PG_FN_IN;
    end
  end

  // Port F pin drive
  always_comb begin
    unique case (f1_fn)
      pg_pkg::PG_FN_IN: begin
        pf_pin_out[1] = 1'b0;
        pf_pin_oe_out[1] = 1'b0;
      end
      pg_pkg::PG_FN_PORT_OUT: begin
        pf_pin_out[1] = regs_q.cfg[`PG_CFG_F1DAT];
        pf_pin_oe_out[1] = 1'b1;
      end
      pg_pkg::PG_FN_SELECT_OUT: begin
        pf_pin_out[1] = chip_select_n_in[5];
        pf_pin_oe_out[1] = !sw_standby_in || keep_out;
      end
      pg_pkg::PG_FN_BUS_REL: begin
        pf_pin_out[1] = bus_ack_n_in;
        pf_pin_oe_out[1] = !sw_standby_in || keep_out;
      end
    endcase
    unique case (f0_fn)
      pg_pkg::PG_FN_PORT_OUT: begin
        pf_pin_out[0] = regs_q.cfg[`PG_CFG_F0DAT];
        pf_pin_oe_out[0] = 1'b1;
      end
      pg_pkg::PG_FN_SELECT_OUT: begin
        pf_pin_out[0] = chip_select_n_in[4];
        pf_pin_oe_out[0] = !sw_standby_in || keep_out;
      end
      pg_pkg::PG_FN_IN, pg_pkg::PG_FN_BUS_REL: begin
        pf_pin_out[0] = 1'b0;
        pf_pin_oe_out[0] = 1'b0;
      end
    endcase
  end

  assign bus_request_input_out = (f0_fn == pg_pkg::PG_FN_BUS_REL) ? pf_pin_in[0] : 1'b1;
  assign ext_interrupt_zero_out = pf_pin_in[0];
  assign ext_interrupt_one_out = pf_pin_in[1];
  assign ext_interrupt_six_out = pg_pin_in[2];
  assign ext_interrupt_seven_out = pg_pin_in[1];
  assign converter_trigger_input_out = pg_pin_in[0];

  // Port G chip-select routing: pin 0..3
  always_comb begin
    pg_sel_en = 5'h00;
    pg_sel_val = 5'h1f;
    if (bus_mode) begin
      pg_sel_en[0] = 1'b1;
      pg_sel_val[0] = chip_select_n_in[0];
      pg_sel_en[1] = regs_q.fc1[`PG_FC1_CSS36] ? cs167e : select_group_two_to_five_enable;
      pg_sel_val[1] = regs_q.fc1[`PG_FC1_CSS36] ? chip_select_n_in[6] : chip_select_n_in[3];
      pg_sel_en[2] = select_group_two_to_five_enable;
      pg_sel_val[2] = chip_select_n_in[2];
      pg_sel_en[3] = cs167e;
      pg_sel_val[3] = regs_q.fc1[`PG_FC1_CSS17] ? chip_select_n_in[7] : chip_select_n_in[1];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `PG_PORT_W; gi++) begin : g_pin
      always_comb begin
        if (!regs_q.dir[gi]) begin
          pg_pin_out[gi] = 1'b0;
          pg_pin_oe_out[gi] = 1'b0;
        end else if (pg_sel_en[gi]) begin
          pg_pin_out[gi] = pg_sel_val[gi];
          pg_pin_oe_out[gi] = !sw_standby_in || keep_out;
        end else begin
          pg_pin_out[gi] = regs_q.data[gi];
          pg_pin_oe_out[gi] = 1'b1;
        end
      end
      assign pg_view[gi] = regs_q.dir[gi] ? regs_q.data[gi] : pg_pin_in[gi];
    end
  endgenerate

  // Register and pin view update
  assign do_write = aw_full_q && w_full_q && !bvalid_q;
  always_comb begin
    regs_d = regs_q;
    hit_w = 1'b1;
    if (do_write && wstrb_q) begin
      unique case (awaddr_q)
        `PG_ADDR_DIR: regs_d.dir = wdata_q[4:0];
        `PG_ADDR_DATA: regs_d.data = wdata_q[4:0];
        `PG_ADDR_PIN: hit_w = 1'b1;
        `PG_ADDR_FC1: regs_d.fc1 = wdata_q;
        `PG_ADDR_FC2: regs_d.fc2 = {wdata_q[7:3], regs_q.fc2[2:0]};
        `PG_ADDR_CFG: regs_d.cfg = {2'h0, wdata_q[5:0]};
        default: hit_w = 1'b0;
      endcase
    end else if (do_write) begin
      unique case (awaddr_q)
        `PG_ADDR_DIR, `PG_ADDR_DATA, `PG_ADDR_PIN, `PG_ADDR_FC1, `PG_ADDR_FC2, `PG_ADDR_CFG: hit_w = 1'b1;
        default: hit_w = 1'b0;
      endcase
    end
    pin_view_d = sw_standby_in ? pin_view_q : pg_view;
  end

  // Read decode
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    unique case (s_axi_araddr_in[15:0])
      `PG_ADDR_DIR: rd_byte = 8'h00;
      `PG_ADDR_DATA: rd_byte = {3'h0, regs_q.data};
      `PG_ADDR_PIN: rd_byte = {3'h0, pin_view_q};
      `PG_ADDR_FC1: rd_byte = regs_q.fc1;
      `PG_ADDR_FC2: rd_byte = regs_q.fc2;
      `PG_ADDR_CFG: rd_byte = regs_q.cfg;
      default: rd_hit = 1'b0;
    endcase
  end

  // AXI4-Lite handshake
  assign s_axi_awready_out = !aw_full_q;
  assign s_axi_wready_out = !w_full_q;
  assign s_axi_arready_out = !rvalid_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;

  // Write channel next state
  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d = w_full_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (s_axi_awvalid_in && !aw_full_q) begin
      aw_full_d = 1'b1;
      awaddr_d = s_axi_awaddr_in[15:0];
    end
    if (s_axi_wvalid_in && !w_full_q) begin
      w_full_d = 1'b1;
      wdata_d = s_axi_wdata_in[7:0];
      wstrb_d = s_axi_wstrb_in[0];
    end
    if (do_write) begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = hit_w ? 2'h0 : 2'h3;
    end
    if (bvalid_q && s_axi_bready_in) begin
      bvalid_d = 1'b0;
    end
  end

  // Read channel next state
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid_in && !rvalid_q) begin
      rvalid_d = 1'b1;
      rdata_d = {24'h000000, rd_byte};
      rresp_d = rd_hit ? 2'h0 : 2'h3;
    end else if (rvalid_q && s_axi_rready_in) begin
      rvalid_d = 1'b0;
    end
  end

  // Register and pin view state
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      regs_q.dir <= dir_rst;
      regs_q.data <= `PG_DATA_RST;
      regs_q.fc1 <= `PG_FC1_RST;
      regs_q.fc2 <= `PG_FC2_RST;
      regs_q.cfg <= `PG_CFG_RST;
      pin_view_q <= pg_pin_in;
    end else begin
      regs_q <= regs_d;
      pin_view_q <= pin_view_d;
    end
  end

  // Write channel state
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 16'h0000;
      wdata_q <= 8'h00;
      wstrb_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  // Read channel state
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= 2'h0;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end
endmodule

/* File: verification/pg_pins_model.sv */
module pg_pins_model (
  // Device side
  input wire logic [4:0] pg_pin_out,
  input wire logic [4:0] pg_pin_oe_out,
  input wire logic [1:0] pf_pin_out,
  input wire logic [1:0] pf_pin_oe_out,
  // External sources
  input wire logic [4:0] ext_g,
  input wire logic [1:0] ext_f,
  // Wire levels
  output logic [4:0] pg_pin_in,
  output logic [1:0] pf_pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Outside sources drive only pins the device leaves free
  assign pg_pin_in = (pg_pin_oe_out & pg_pin_out) | (~pg_pin_oe_out & ext_g);
  assign pf_pin_in = (pf_pin_oe_out & pf_pin_out) | (~pf_pin_oe_out & ext_f);
endmodule

/* File: verification/pg_port_props.sv */
module pg_port_props (
  // Clock, reset, mode
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [2:0] mode_in,
  input wire logic rom_less_in,
  // Bus handshakes
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out,
  // Pins and decoded inputs
  input wire logic [4:0] pg_pin_in,
  input wire logic [4:0] pg_pin_oe_out,
  input wire logic [1:0] pf_pin_in,
  input wire logic ext_interrupt_zero_out,
  input wire logic ext_interrupt_one_out,
  input wire logic ext_interrupt_six_out,
  input wire logic ext_interrupt_seven_out,
  input wire logic converter_trigger_input_out,
  input wire logic mode_error_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  property p_irq_f;
    ext_interrupt_zero_out == pf_pin_in[0] && ext_interrupt_one_out == pf_pin_in[1];
  endproperty
  a_irq_f: assert property (p_irq_f) else $error("interrupt 0/1 mapping");
  property p_irq_g;
    ext_interrupt_six_out == pg_pin_in[2] && ext_interrupt_seven_out == pg_pin_in[1]
      && converter_trigger_input_out == pg_pin_in[0];
  endproperty
  a_irq_g: assert property (p_irq_g) else $error("port g input mapping");
  property p_mode_err;
    mode_error_out == (rom_less_in && mode_in[2:1] == 2'h3);
  endproperty
  a_mode_err: assert property (p_mode_err) else $error("mode error flag");
  property p_dir_rst;
    $fell(reset_in) |-> pg_pin_oe_out == (mode_in[2:1] == 2'h2 ? 5'h10 : 5'h00);
  endproperty
  a_dir_rst: assert property (p_dir_rst) else $error("direction reset value");
  property p_bus_rst;
    $fell(reset_in) |-> !s_axi_bvalid_out && !s_axi_rvalid_out;
  endproperty
  a_bus_rst: assert property (p_bus_rst) else $error("valid after reset");
  property p_wr_ans;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out |-> ##[1:2] s_axi_bvalid_out;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_rd_ans;
    s_axi_arvalid_in && s_axi_arready_out |-> ##[1:2] s_axi_rvalid_out;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_b_hold;
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_byte;
    s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0;
  endproperty
  a_byte: assert property (p_byte) else $error("upper read bits set");
  c_wr: cover property (s_axi_bvalid_out && s_axi_bready_in);
  c_rd: cover property (s_axi_rvalid_out && s_axi_rready_in);
  c_err: cover property (mode_error_out);
endmodule
bind pg_port pg_port_props pg_port_props_inst (.*);

/* File: verification/port_g_and_pf1_pf0_pin_logic_test.sv */
`include "pg_params.svh"
module port_g_and_pf1_pf0_pin_logic_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'h0, reset_in = 1'h1, rom_less_in = 1'h0, sw_standby_in = 1'h0, bus_ack_n_in = 1'h1;
  logic [2:0] mode_in = 3'h4;
  logic [31:0] s_axi_awaddr_in = 32'h0, s_axi_wdata_in = 32'h0, s_axi_araddr_in = 32'h0, s_axi_rdata_out, rv;
  logic [3:0] s_axi_wstrb_in = 4'h0;
  logic s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0, s_axi_bready_in = 1'h0;
  logic s_axi_arvalid_in = 1'h0, s_axi_rready_in = 1'h0;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, pf_pin_in, pf_pin_out, pf_pin_oe_out, rs, ext_f = 2'h0;
  logic [4:0] pg_pin_in, pg_pin_out, pg_pin_oe_out, ext_g = 5'h15;
  logic [7:0] chip_select_n_in = 8'hff;
  logic ext_interrupt_zero_out, ext_interrupt_one_out, ext_interrupt_six_out, ext_interrupt_seven_out;
  logic converter_trigger_input_out, bus_request_input_out, mode_error_out;
  int errors = 0, checks_done = 0, cycles = 0;
  pg_port pg_port_inst (.*);
  pg_pins_model pg_pins_model_inst (.*);
  initial forever #50 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      wrap_up();
    end
  end
  task wrap_up;
    $display("Checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task rst(input logic [2:0] m);
    mode_in <= m;
    reset_in <= 1'h1;
    repeat (6) @(posedge clk_in);
    reset_in <= 1'h0;
    @(posedge clk_in);
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ta, tw, bv, dn;
    dn = 1'h0;
    s_axi_awaddr_in <= {16'h1, a};
    s_axi_wdata_in <= {24'h0, d};
    s_axi_wstrb_in <= 4'h1;
    s_axi_awvalid_in <= 1'h1;
    s_axi_wvalid_in <= 1'h1;
    s_axi_bready_in <= 1'h1;
    while (!dn) begin
      @(negedge clk_in);
      ta = s_axi_awvalid_in && s_axi_awready_out;
      tw = s_axi_wvalid_in && s_axi_wready_out;
      bv = s_axi_bvalid_out;
      dn = bv && s_axi_bready_in;
      r = s_axi_bresp_out;
      @(posedge clk_in);
      if (ta) s_axi_awvalid_in <= 1'h0;
      if (tw) s_axi_wvalid_in <= 1'h0;
    end
  endtask
  task rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, v, dn;
    dn = 1'h0;
    s_axi_araddr_in <= {16'h0, a};
    s_axi_arvalid_in <= 1'h1;
    s_axi_rready_in <= 1'h1;
    while (!dn) begin
      @(negedge clk_in);
      ta = s_axi_arvalid_in && s_axi_arready_out;
      v = s_axi_rvalid_out;
      dn = v && s_axi_rready_in;
      d = s_axi_rdata_out;
      r = s_axi_rresp_out;
      @(posedge clk_in);
      if (ta) s_axi_arvalid_in <= 1'h0;
    end
  endtask
  task rc(input logic [15:0] a, input logic [7:0] e, input string nm);
    rd(a, rv, rs);
    chk(nm, rv, {24'h0, e});
  endtask
  task t_reset;
    rc(`PG_ADDR_DATA, 8'h00, "data reset");
    rc(`PG_ADDR_FC1, 8'h0f, "fc1 reset");
    rc(`PG_ADDR_FC2, 8'h30, "fc2 reset");
    chk("dir reset m4", pg_pin_oe_out, 5'h10);
  endtask
  task t_data;
    wr(`PG_ADDR_DATA, 8'hff, rs);
    rc(`PG_ADDR_DATA, 8'h1f, "data reserved");
    wr(`PG_ADDR_DATA, 8'h0a, rs);
    rc(`PG_ADDR_DATA, 8'h0a, "upper addr ignored");
    wr(16'hff01, 8'h55, rs);
    chk("unmapped wr", rs, 2'h3);
    rd(16'hff01, rv, rs);
    chk("unmapped rd", rs, 2'h3);
  endtask
  task t_pin;
    wr(`PG_ADDR_DIR, 8'h0f, rs);
    chk("oe follows dir", pg_pin_oe_out, 5'h0f);
    chk("pg0 select", pg_pin_out[0], 1'h1);
    rc(`PG_ADDR_PIN, 8'h1a, "pin mix");
    wr(`PG_ADDR_PIN, 8'h00, rs);
    rc(`PG_ADDR_DATA, 8'h0a, "pin write ignored");
    sw_standby_in <= 1'h1;
    ext_g <= 5'h05;
    rc(`PG_ADDR_PIN, 8'h1a, "standby hold");
    chk("standby float", pg_pin_oe_out, 5'h00);
    sw_standby_in <= 1'h0;
    @(posedge clk_in);
    rc(`PG_ADDR_PIN, 8'h0a, "pin follows");
  endtask
  task t_pf;
    chip_select_n_in <= 8'hcf;
    bus_ack_n_in <= 1'h0;
    wr(`PG_ADDR_FC1, 8'h2f, rs);
    wr(`PG_ADDR_CFG, 8'h14, rs);
    chk("f1 cs5 oe", pf_pin_oe_out[1], 1'h1);
    chk("f1 cs5", pf_pin_out[1], 1'h0);
    wr(`PG_ADDR_FC1, 8'h0f, rs);
    chk("f1 port", pf_pin_out[1], 1'h1);
    wr(`PG_ADDR_CFG, 8'h15, rs);
    chk("f1 ack", pf_pin_out[1], 1'h0);
    chk("f0 in", pf_pin_oe_out[0], 1'h0);
    chk("request", bus_request_input_out, 1'h0);
    wr(`PG_ADDR_CFG, 8'h00, rs);
    chk("request idle", bus_request_input_out, 1'h1);
    chk("f1 input", pf_pin_oe_out[1], 1'h0);
    wr(`PG_ADDR_FC1, 8'h1f, rs);
    wr(`PG_ADDR_CFG, 8'h28, rs);
    chk("f0 cs4", pf_pin_out[0], 1'h0);
    wr(`PG_ADDR_CFG, 8'h00, rs);
    wr(`PG_ADDR_DIR, 8'h00, rs);
    wr(`PG_ADDR_FC2, 8'h20, rs);
    rc(`PG_ADDR_FC2, 8'h20, "fc2 group off");
    wr(`PG_ADDR_CFG, 8'h28, rs);
    chk("f0 group off", pf_pin_out[0], 1'h1);
  endtask
  task t_mode7;
    rst(3'h7);
    chk("dir reset m7", pg_pin_oe_out, 5'h00);
    wr(`PG_ADDR_CFG, 8'h15, rs);
    chk("m7 f1 port", pf_pin_out[1], 1'h1);
    rom_less_in <= 1'h1;
    @(posedge clk_in);
    chk("mode error", mode_error_out, 1'h1);
  endtask
  initial begin
    rst(3'h4);
    t_reset();
    t_data();
    t_pin();
    t_pf();
    t_mode7();
    wrap_up();
  end
endmodule
